// ===== common/cbwp_pkg.sv
// constants, types and helpers for the bus write, i/o and irq port
package cbwp_pkg;

  // ----------------------------------------------------------------
  // bus width codes
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // ----------------------------------------------------------------
  // bus status codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CAUSE_RUN = 2'h0;
  localparam logic [4:0] STAT_IDLE_BASE = 5'h00;
  localparam logic [4:0] STAT_READ = 5'h0a;
  localparam logic [4:0] STAT_WRITE = 5'h0b;

  // ----------------------------------------------------------------
  // lane layout and reset values
  // ----------------------------------------------------------------
  localparam int LANES = 4;
  localparam logic [3:0] LANES_LOW = 4'h3;
  localparam logic [3:0] LANES_HIGH = 4'hc;
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [1:0] HALF2_OFFSET = 2'h2;
  localparam int PIN_WIDTH = 40;
  localparam logic [39:0] PIN_RESET = 40'h00000000ff;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_T1 = 2'b01,
    ST_T2 = 2'b10,
    ST_GRANT = 2'b11
  } cbwp_state_type;

  // ----------------------------------------------------------------
  // lane helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] cbwp_mask(input logic [2:0] size,
                                           input logic [1:0] off);
    logic [4:0] ones;
    logic [7:0] wide;
    ones = 5'((5'h01 << size) - 5'h01);
    wide = 8'({3'h0, ones} << off);
    return wide[3:0];
  endfunction

  function automatic logic [31:0] cbwp_dup(input logic [31:0] s,
                                           input logic [3:0] m);
    logic [7:0] lane1;
    logic [7:0] lane0;
    // upper half copied down when no low lane is written
    lane1 = (m[1:0] == 2'h0) ? s[31:24] : s[15:8];
    // lowest written lane always copied onto lane 0
    if (m[0]) begin
      lane0 = s[7:0];
    end else if (m[1]) begin
      lane0 = s[15:8];
    end else if (m[2]) begin
      lane0 = s[23:16];
    end else begin
      lane0 = s[31:24];
    end
    return {s[31:16], lane1, lane0};
  endfunction

endpackage

// ===== rtl/cbwp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module cbwp_sync
  import cbwp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  // pins and synchronised copy
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } cbwp_sync_state_type;

  cbwp_sync_state_type r_q;
  cbwp_sync_state_type r_d;

  always_comb begin
    r_d = r_q;
    r_d.stage1 = pinIn;
    r_d.stage2 = r_q.stage1;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= {RESET_VALUE, RESET_VALUE};
    end else if (clockEnable) begin
      r_q <= r_d;
    end
  end

  assign syncOut = r_q.stage2;

endmodule

// ===== rtl/cbwp_edge_latch.sv
// falling edge detector with a sticky pending latch
`timescale 1ns/10ps
module cbwp_edge_latch
  import cbwp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  // sampled line
  input wire logic sampleEn,
  input wire logic lineN,
  // pending request
  input wire logic clearPulse,
  output logic pending
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic prev;
    logic pending;
  } cbwp_edge_state_type;

  cbwp_edge_state_type r_q;
  cbwp_edge_state_type r_d;
  logic fall;

  always_comb begin
    r_d = r_q;
    fall = sampleEn && r_q.prev && !lineN;
    if (sampleEn) begin
      r_d.prev = lineN;
    end
    if (clearPulse) begin
      r_d.pending = 1'b0;
    end
    // set wins over clear
    if (fall) begin
      r_d.pending = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= '{prev: 1'b1, pending: 1'b0};
    end else if (clockEnable) begin
      r_q <= r_d;
    end
  end

  assign pending = r_q.pending;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  edgeSetsPending_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (clockEnable && sampleEn && r_q.prev && !lineN) |=> pending)
    else $error("falling edge did not set pending");

  pendingOnlyEdge_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $rose(pending) |-> $past(sampleEn) && !$past(lineN))
    else $error("pending rose without a sampled falling edge");

endmodule

// ===== rtl/cbwp_port.sv
// bus write splitter, hold arbiter, i/o qualifier and irq sampler
`timescale 1ns/10ps
module cbwp_port
  import cbwp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  // access request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqLocked,
  input wire logic reqInhibit,
  input wire logic reqBurst,
  input wire logic [31:0] reqAddr,
  input wire logic [31:0] reqData,
  input wire logic [2:0] reqSize,
  input wire logic [1:0] busWidth,
  input wire logic [1:0] idleCause,
  output logic reqReady,
  // access result
  output logic seqDone,
  output logic seqError,
  output logic rdValid,
  output logic [31:0] rdData,
  output logic ioSpecial,
  output logic noncacheable,
  // bus pins
  output logic [31:0] busAddr,
  output logic [3:0] byte_lane_enables,
  output logic [31:0] busDataOut,
  output logic busCycle,
  output logic busWriteCycle,
  output logic [4:0] busStatus,
  output logic io_inhibit,
  output logic bus_hold_grant,
  input wire logic [31:0] busDataIn,
  input wire logic busReadyN,
  input wire logic busErrorN,
  input wire logic bus_retry_in,
  input wire logic io_decode_in,
  input wire logic holdReqN,
  // interrupt pins and requests
  input wire logic maskable_irq_n,
  input wire logic nonmaskable_irq_n,
  input wire logic debug_trap_req_n,
  input wire logic nmiAck,
  input wire logic debugAck,
  output logic intRequest,
  output logic nmiPending,
  output logic debugPending
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cbwp_state_type state;
    logic [31:0] curAddr;
    logic [31:0] dataS;
    logic [3:0] mask;
    logic [1:0] width;
    logic isWrite;
    logic inhibit;
    logic burst;
    logic lockActive;
    logic ioDecSample;
    logic phase;
    logic intLevel;
    logic [3:0] outBe;
    logic [31:0] outData;
    logic cycle;
    logic ioInhibit;
    logic grant;
    logic [4:0] status;
    logic ready;
    logic seqDone;
    logic seqError;
    logic rdValid;
    logic [31:0] rdData;
    logic ioSpecial;
    logic noncache;
  } cbwp_port_state_type;

  cbwp_port_state_type r_q;
  cbwp_port_state_type r_d;
  logic [39:0] pinSync;
  logic decActive;
  logic rdyActive;
  logic errActive;
  logic rtyActive;
  logic holdActive;
  logic [3:0] written;
  logic [3:0] remain;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  cbwp_sync #(
    .WIDTH(PIN_WIDTH),
    .RESET_VALUE(PIN_RESET)
  ) pinSyncInst (
    .clock(clock),
    .reset_n(reset_n),
    .clockEnable(clockEnable),
    .pinIn({busDataIn, debug_trap_req_n, nonmaskable_irq_n,
            maskable_irq_n, holdReqN, bus_retry_in, busErrorN,
            busReadyN, io_decode_in}),
    .syncOut(pinSync)
  );

  assign decActive = !pinSync[0];
  assign rdyActive = !pinSync[1];
  assign errActive = !pinSync[2];
  assign rtyActive = !pinSync[3];
  assign holdActive = !pinSync[4];

  // ----------------------------------------------------------------
  // edge latches
  // ----------------------------------------------------------------
  cbwp_edge_latch nmiLatch (
    .clock(clock),
    .reset_n(reset_n),
    .clockEnable(clockEnable),
    .sampleEn(r_q.phase),
    .lineN(pinSync[6]),
    .clearPulse(nmiAck),
    .pending(nmiPending)
  );

  cbwp_edge_latch debugLatch (
    .clock(clock),
    .reset_n(reset_n),
    .clockEnable(clockEnable),
    .sampleEn(1'b1),
    .lineN(pinSync[7]),
    .clearPulse(debugAck),
    .pending(debugPending)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.seqDone = 1'b0;
    r_d.seqError = 1'b0;
    r_d.rdValid = 1'b0;
    r_d.ioSpecial = 1'b0;
    r_d.noncache = 1'b0;
    written = MASK_NONE;
    remain = MASK_NONE;
    // irq sampling on alternate edges
    r_d.phase = !r_q.phase;
    if (r_q.phase) begin
      r_d.intLevel = !pinSync[5];
    end
    case (r_q.state)
      ST_IDLE: begin
        if (holdActive && !r_q.lockActive) begin
          r_d.state = ST_GRANT;
          r_d.grant = 1'b1;
          r_d.ready = 1'b0;
        end else if (reqValid && r_q.ready) begin
          r_d.state = ST_T1;
          r_d.ready = 1'b0;
          r_d.curAddr = reqAddr;
          r_d.mask = cbwp_mask(reqSize, reqAddr[1:0]);
          r_d.dataS = reqData << {reqAddr[1:0], 3'h0};
          r_d.width = busWidth;
          r_d.isWrite = reqWrite;
          r_d.burst = reqBurst;
          r_d.cycle = 1'b1;
          r_d.ioInhibit = !reqWrite && reqInhibit;
          r_d.status = reqWrite ? STAT_WRITE : STAT_READ;
          if (!reqWrite && reqLocked) begin
            r_d.lockActive = 1'b1;
          end
        end else begin
          r_d.ready = !holdActive || r_q.lockActive;
        end
      end
      ST_T1: begin
        r_d.state = ST_T2;
        r_d.ioDecSample = 1'b0;
      end
      ST_T2: begin
        // latest sample of the wait states wins; bursts ignore it
        r_d.ioDecSample = decActive && !r_q.burst;
        if (errActive) begin
          r_d.state = ST_IDLE;
          r_d.seqError = 1'b1;
          r_d.lockActive = 1'b0;
        end else if (rtyActive) begin
          r_d.state = ST_T1;
        end else if (rdyActive) begin
          if (r_q.isWrite) begin
            if (r_q.width == WIDTH_16) begin
              written = r_q.curAddr[1] ? LANES_HIGH : LANES_LOW;
              remain = r_q.mask & ~written;
            end else if (r_q.width == WIDTH_8) begin
              remain = r_q.mask & 4'(r_q.mask - 4'h1);
            end
          end
          if (remain != MASK_NONE) begin
            r_d.state = ST_T1;
            r_d.mask = remain;
            if (r_q.width == WIDTH_16) begin
              r_d.curAddr = {r_q.curAddr[31:2], HALF2_OFFSET};
            end else begin
              r_d.curAddr = 32'(r_q.curAddr + 32'h1);
            end
          end else begin
            r_d.state = ST_IDLE;
            r_d.seqDone = 1'b1;
            if (r_q.isWrite) begin
              r_d.lockActive = 1'b0;
            end else begin
              r_d.noncache = decActive && !r_q.burst;
              r_d.ioSpecial = decActive && !r_q.burst
                              && r_q.ioInhibit;
              r_d.rdValid = !(decActive && !r_q.burst && r_q.ioInhibit);
              r_d.rdData = pinSync[39:8];
            end
          end
        end
      end
      ST_GRANT: begin
        if (!holdActive) begin
          r_d.state = ST_IDLE;
          r_d.grant = 1'b0;
        end
      end
      default: begin
        r_d.state = ST_IDLE;
      end
    endcase
    if (r_d.state == ST_IDLE || r_d.state == ST_GRANT) begin
      r_d.cycle = 1'b0;
      r_d.ioInhibit = 1'b0;
      r_d.status = STAT_IDLE_BASE | {3'h0, idleCause};
    end
    r_d.outBe = ~r_d.mask;
    r_d.outData = cbwp_dup(r_d.dataS, r_d.mask);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= '{state: ST_IDLE, outBe: 4'hf, status: STAT_IDLE_BASE,
               default: '0};
    end else if (clockEnable) begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reqReady = r_q.ready;
  assign seqDone = r_q.seqDone;
  assign seqError = r_q.seqError;
  assign rdValid = r_q.rdValid;
  assign rdData = r_q.rdData;
  assign ioSpecial = r_q.ioSpecial;
  assign noncacheable = r_q.noncache;
  assign busAddr = r_q.curAddr;
  assign byte_lane_enables = r_q.outBe;
  assign busDataOut = r_q.outData;
  assign busCycle = r_q.cycle;
  assign busWriteCycle = r_q.isWrite;
  assign busStatus = r_q.status;
  assign io_inhibit = r_q.ioInhibit;
  assign bus_hold_grant = r_q.grant;
  assign intRequest = r_q.intLevel;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sixteenUpper_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (busCycle && busWriteCycle && r_q.width == WIDTH_16 && busAddr[1])
    |-> byte_lane_enables[1:0] == 2'h3
        && (byte_lane_enables[2] || busDataOut[7:0] == r_q.dataS[23:16])
        && (byte_lane_enables[3] || busDataOut[15:8] == r_q.dataS[31:24]))
    else $error("16-bit upper cycle lanes wrong");

  eightLaneZero_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (clockEnable && r_q.state == ST_T2 && r_q.isWrite && rdyActive
     && !errActive && !rtyActive && r_q.width == WIDTH_8
     && r_q.mask == 4'h3)
    |=> r_q.mask == 4'h2 && busAddr == $past(busAddr) + 32'h1
        && busDataOut[7:0] == r_q.dataS[15:8])
    else $error("8-bit next byte cycle wrong");

  enableLow_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    busCycle |-> byte_lane_enables != 4'hf
                 && byte_lane_enables == ~r_q.mask)
    else $error("byte enables not active low");

  grantIdle_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    bus_hold_grant |-> !busCycle && busStatus[4:2] == 3'h0)
    else $error("status not idle while granted");

  grantCause_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (clockEnable && bus_hold_grant && holdActive)
    |=> busStatus == (STAT_IDLE_BASE | {3'h0, $past(idleCause)}))
    else $error("idle status did not follow cause");

  grantNoLock_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $rose(bus_hold_grant) |-> !$past(r_q.lockActive))
    else $error("bus granted inside interlocked pair");

  holdImmediate_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (clockEnable && r_q.state == ST_IDLE && holdActive && !r_q.lockActive)
    |=> bus_hold_grant)
    else $error("idle hold not granted at once");

  writeNoInhibit_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    (busCycle && busWriteCycle) |-> !io_inhibit)
    else $error("io_inhibit during write");

  specialNoData_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    ioSpecial |-> !rdValid && noncacheable)
    else $error("special i/o read delivered data");

  errorDiscard_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    seqError |-> !ioSpecial && !noncacheable && !seqDone)
    else $error("decode used on error cycle");

  intAlternate_a: assert property (
    @(posedge clock) disable iff (!reset_n)
    $changed(intRequest) |-> $past(r_q.phase))
    else $error("maskable level sampled off phase");

endmodule

// ===== testbench/cbwp_system_model.sv
// system side model: memory reply, i/o decode and read data
`timescale 1ns/10ps
module cbwp_system_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // bus from the port
  input wire logic busCycle,
  input wire logic busWriteCycle,
  input wire logic [31:0] busAddr,
  // reply control
  input wire logic [3:0] waitStates,
  input wire logic burst,
  input wire logic errorReply,
  input wire logic retryReply,
  // replies
  output logic [31:0] busDataIn,
  output logic busReadyN,
  output logic busErrorN,
  output logic bus_retry_in,
  output logic io_decode_in
);
  logic [3:0] cnt_q;
  logic [31:0] addr_q;
  logic [31:0] idle_q;
  logic reply;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 4'h0;
      addr_q <= 32'h0;
      idle_q <= 32'h5a5a5a5a;
    end else begin
      addr_q <= busAddr;
      idle_q <= ~idle_q;
      if (!busCycle || busAddr != addr_q)
        cnt_q <= 4'h0;
      else if (cnt_q != 4'hf)
        cnt_q <= cnt_q + 4'h1;
    end
  end
  assign reply = busCycle && busAddr == addr_q && cnt_q >= waitStates;
  assign busReadyN = !(reply && !errorReply && !retryReply);
  assign busErrorN = !(reply && errorReply);
  // retry repeats the cycle for as long as it is requested
  assign bus_retry_in = !(reply && retryReply && !errorReply);
  // decode for the whole cycle, never in bursts
  assign io_decode_in = !(busCycle && busAddr[31:28] == 4'hf && !burst);
  // released data lines toggle every cycle
  assign busDataIn = (busCycle && !busWriteCycle) ? ~busAddr : idle_q;
endmodule

// ===== testbench/tb_cbwp_port.sv
// self-checking bench for the bus write, i/o and irq port
`timescale 1ns/10ps
module tb_cbwp_port
  import cbwp_pkg::*;
;
  typedef struct packed {
    logic [1:0] width;
    logic [1:0] lsb;
    logic [2:0] size;
    logic [2:0] n;
    logic [15:0] bes;
  } cbwp_row_type;
  localparam logic [31:0] OPD = 32'h44332211;
  cbwp_row_type rows[17] = '{
    '{WIDTH_16, 2'h3, 3'h1, 3'h1, 16'h7000},
    '{WIDTH_16, 2'h0, 3'h2, 3'h1, 16'hc000},
    '{WIDTH_16, 2'h1, 3'h2, 3'h2, 16'h9b00},
    '{WIDTH_16, 2'h2, 3'h2, 3'h1, 16'h3000},
    '{WIDTH_16, 2'h0, 3'h3, 3'h2, 16'h8b00},
    '{WIDTH_16, 2'h1, 3'h3, 3'h2, 16'h1300},
    '{WIDTH_16, 2'h0, 3'h4, 3'h2, 16'h0300},
    '{WIDTH_8, 2'h1, 3'h1, 3'h1, 16'hd000},
    '{WIDTH_8, 2'h0, 3'h2, 3'h2, 16'hcd00},
    '{WIDTH_8, 2'h1, 3'h2, 3'h2, 16'h9b00},
    '{WIDTH_8, 2'h2, 3'h2, 3'h2, 16'h3700},
    '{WIDTH_8, 2'h0, 3'h3, 3'h3, 16'h89b0},
    '{WIDTH_8, 2'h1, 3'h3, 3'h3, 16'h1370},
    '{WIDTH_8, 2'h0, 3'h4, 3'h4, 16'h0137},
    '{WIDTH_32, 2'h1, 3'h2, 3'h1, 16'h9000},
    '{WIDTH_32, 2'h0, 3'h4, 3'h1, 16'h0000},
    '{WIDTH_32, 2'h2, 3'h1, 3'h1, 16'hb000}};
  logic clock, reset_n, reqValid, reqWrite, reqLocked, reqInhibit, reqBurst;
  logic [31:0] reqAddr, reqData, rdData, busAddr, busDataOut, busDataIn, ea;
  logic [2:0] reqSize;
  logic [1:0] busWidth, idleCause, prevCause;
  logic reqReady, seqDone, seqError, rdValid, ioSpecial, noncacheable;
  logic [3:0] byte_lane_enables, waitStates, be;
  logic busCycle, busWriteCycle, io_inhibit, bus_hold_grant, busReadyN;
  logic [4:0] busStatus;
  logic busErrorN, io_decode_in, holdReqN, maskable_irq_n, errorReply;
  logic bus_retry_in, retryReply;
  logic nonmaskable_irq_n, debug_trap_req_n, nmiAck, debugAck;
  logic intRequest, nmiPending, debugPending;
  logic fErr, fRd, fSpec, fNc, sawInh, lockOpen, lastCyc;
  logic [35:0] lastKey;
  logic [67:0] cycQ[$];
  cbwp_row_type row;
  int checks, n_mismatch, cycles, lo, low;

  cbwp_port cbwp_port_inst (.clock, .reset_n, .clockEnable(1'b1),
    .reqValid, .reqWrite, .reqLocked, .reqInhibit, .reqBurst, .reqAddr,
    .reqData, .reqSize, .busWidth, .idleCause, .reqReady, .seqDone,
    .seqError, .rdValid, .rdData, .ioSpecial, .noncacheable, .busAddr,
    .byte_lane_enables, .busDataOut, .busCycle, .busWriteCycle, .busStatus,
    .io_inhibit, .bus_hold_grant, .busDataIn, .busReadyN, .busErrorN,
    .bus_retry_in, .io_decode_in, .holdReqN, .maskable_irq_n,
    .nonmaskable_irq_n, .debug_trap_req_n, .nmiAck, .debugAck, .intRequest,
    .nmiPending, .debugPending);
  cbwp_system_model cbwp_system_model_inst (.clock, .reset_n, .busCycle,
    .busWriteCycle, .busAddr, .waitStates, .burst(reqBurst), .errorReply,
    .retryReply, .busDataIn, .busReadyN, .busErrorN, .bus_retry_in,
    .io_decode_in);

  always #5 clock = ~clock;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e,
                       input logic [31:0] g);
    checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // idle cause as the port last registered it
  always @(posedge clock)
    prevCause <= idleCause;
  // bus cycle capture and standing checks
  always @(negedge clock) begin
    if (busCycle && (!lastCyc || lastKey != {busAddr, byte_lane_enables}))
      cycQ.push_back({busAddr, byte_lane_enables, busDataOut});
    lastCyc = busCycle;
    lastKey = {busAddr, byte_lane_enables};
    if (busCycle && !busWriteCycle && io_inhibit)
      sawInh = 1'b1;
    if (busCycle && busWriteCycle)
      check("write inhibit", 32'h0, 32'(io_inhibit));
    if (bus_hold_grant === 1'b1) begin
      check("grant in cycle", 32'h0, 32'(busCycle));
      check("grant in lock", 32'h0, 32'(lockOpen));
      check("status", 32'(prevCause), 32'(busStatus));
    end
  end
  task automatic run(input logic wr, input logic [1:0] w,
    input logic [31:0] a, input logic [2:0] sz, input logic inh,
    input logic lk, input logic bu);
    int k;
    @(posedge clock);
    reqValid <= 1'b1;
    reqWrite <= wr;
    busWidth <= w;
    reqAddr <= a;
    reqSize <= sz;
    reqInhibit <= inh;
    reqLocked <= lk;
    reqBurst <= bu;
    reqData <= OPD;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (reqReady !== 1'b1 && k < 100);
    @(posedge clock);
    reqValid <= 1'b0;
    {fErr, fRd, fSpec, fNc} = 4'h0;
    k = 0;
    do begin
      @(negedge clock);
      k++;
      fErr |= seqError;
      fRd |= rdValid;
      fSpec |= ioSpecial;
      fNc |= noncacheable;
    end while (seqDone !== 1'b1 && seqError !== 1'b1 && k < 200);
    check("sequence end", 32'h0, 32'(k >= 200));
  endtask
  task automatic rd(input logic [31:0] a, input logic inh,
                    input logic bu, input logic [3:0] e);
    sawInh = 1'b0;
    run(1'b0, WIDTH_32, a, 3'h4, inh, 1'b0, bu);
    check("inhibit", 32'(inh), 32'(sawInh));
    check("read flags", 32'(e), 32'({fErr, fSpec, fNc, fRd}));
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return bus_hold_grant;
      1: return intRequest;
      2: return nmiPending;
      default: return debugPending;
    endcase
  endfunction
  task automatic await(input int s, input logic v, input string what);
    int k;
    k = 0;
    while (sig(s) !== v && k < 8) begin
      @(negedge clock);
      k++;
    end
    check(what, 32'(v), 32'(sig(s)));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {clock, reset_n, reqValid, reqWrite, reqLocked, reqInhibit} = 6'h0;
    {reqBurst, nmiAck, debugAck, errorReply, lockOpen, lastCyc} = 6'h0;
    {holdReqN, maskable_irq_n, nonmaskable_irq_n, debug_trap_req_n} = 4'hf;
    {reqAddr, reqData, reqSize, busWidth, idleCause, waitStates} = 0;
    retryReply = 1'b0;
    repeat (5) @(negedge clock);
    check("reset enables", 32'hf, 32'(byte_lane_enables));
    check("reset grant", 32'h0, 32'(bus_hold_grant));
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    for (int r = 0; r < 17; r++) begin
      row = rows[r];
      lo = int'(row.lsb);
      cycQ.delete();
      run(1'b1, row.width, 32'h1000 + lo, row.size, 1'b0, 1'b0, 1'b0);
      check("cycles", 32'(row.n), 32'(cycQ.size()));
      for (int k = 0; k < int'(row.n) && k < cycQ.size(); k++) begin
        be = row.bes[15 - 4 * k -: 4];
        ea = (row.width == WIDTH_8) ? 32'h1000 + lo + k :
             (k > 0) ? 32'h1002 : 32'h1000 + lo;
        check("enables", 32'(be), 32'(cycQ[k][35:32]));
        check("address", ea, cycQ[k][67:36]);
        low = 0;
        for (int l = 3; l >= 0; l--) begin
          if (!be[l]) begin
            low = l;
            check("lane", 32'(OPD[8*(l-lo) +: 8]), 32'(cycQ[k][8*l +: 8]));
          end
        end
        check("lane 0", 32'(OPD[8*(low-lo) +: 8]), 32'(cycQ[k][7:0]));
      end
    end
    rd(32'hf0000000, 1'b1, 1'b0, 4'h6);
    rd(32'hf0000000, 1'b0, 1'b0, 4'h3);
    rd(32'h00002000, 1'b1, 1'b0, 4'h1);
    rd(32'hf0000000, 1'b1, 1'b1, 4'h1);
    waitStates <= 4'h3;
    rd(32'hf0000000, 1'b1, 1'b0, 4'h6);
    errorReply <= 1'b1;
    sawInh = 1'b0;
    run(1'b0, WIDTH_32, 32'hf0000000, 3'h4, 1'b1, 1'b0, 1'b0);
    check("error flags", 32'h4, 32'({fErr, fSpec, fNc}));
    errorReply <= 1'b0;
    run(1'b1, WIDTH_32, 32'hf0000000, 3'h4, 1'b1, 1'b0, 1'b0);
    @(posedge clock);
    retryReply <= 1'b1;
    fork
      rd(32'hf0000000, 1'b1, 1'b0, 4'h6);
      begin
        repeat (12) @(posedge clock);
        holdReqN <= 1'b0;
        retryReply <= 1'b0;
      end
    join
    await(0, 1'b1, "grant after retry");
    holdReqN <= 1'b1;
    await(0, 1'b0, "release");
    holdReqN <= 1'b0;
    await(0, 1'b1, "idle grant");
    @(posedge clock);
    idleCause <= 2'h3;
    repeat (4) @(negedge clock);
    check("cause", 32'h3, 32'(busStatus));
    holdReqN <= 1'b1;
    await(0, 1'b0, "release");
    fork
      run(1'b1, WIDTH_8, 32'h1000, 3'h4, 1'b0, 1'b0, 1'b0);
      begin
        repeat (4) @(posedge clock);
        holdReqN <= 1'b0;
      end
    join
    await(0, 1'b1, "grant after sequence");
    holdReqN <= 1'b1;
    await(0, 1'b0, "release");
    lockOpen = 1'b1;
    fork
      run(1'b0, WIDTH_32, 32'h2000, 3'h4, 1'b0, 1'b1, 1'b0);
      begin
        repeat (3) @(posedge clock);
        holdReqN <= 1'b0;
      end
    join
    repeat (8) @(negedge clock);
    run(1'b1, WIDTH_32, 32'h2000, 3'h4, 1'b0, 1'b0, 1'b0);
    lockOpen = 1'b0;
    await(0, 1'b1, "grant after pair");
    holdReqN <= 1'b1;
    @(posedge clock);
    maskable_irq_n <= 1'b0;
    await(1, 1'b1, "int request");
    maskable_irq_n <= 1'b1;
    await(1, 1'b0, "int removed");
    for (int ph = 0; ph < 2; ph++) begin
      if (ph == 1)
        @(posedge clock);
      nonmaskable_irq_n <= 1'b0;
      debug_trap_req_n <= 1'b0;
      repeat (2) @(posedge clock);
      nonmaskable_irq_n <= 1'b1;
      debug_trap_req_n <= 1'b1;
      await(2, 1'b1, "nmi pending");
      await(3, 1'b1, "debug pending");
      repeat (6) @(negedge clock);
      check("nmi held", 32'h1, 32'(nmiPending));
      @(posedge clock);
      nmiAck <= 1'b1;
      debugAck <= 1'b1;
      @(posedge clock);
      nmiAck <= 1'b0;
      debugAck <= 1'b0;
      await(2, 1'b0, "nmi cleared");
      await(3, 1'b0, "debug cleared");
    end
    report_and_stop();
  end
endmodule
